// ### src/adc_readout_pkg.sv
// Shared constants and types for the serial result readout block
package adc_readout_pkg;
    // ------------------------------------------------------------------
    // Word and frame geometry
    // ------------------------------------------------------------------
    localparam int unsigned RESULT_W     = 14;
    localparam int unsigned WORD_W       = 16;
    localparam int unsigned CHAN_N       = 8;
    localparam int unsigned GROUP_N      = 4;
    localparam int unsigned CHAN_IDX_W   = 3;
    localparam int unsigned BIT_CNT_W    = 4;
    localparam int unsigned OSR_W        = 3;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hd;
    localparam logic [1:0]           PAD_ZERO = 2'h0;

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned CONV_BASE_NS   = 4000;
    localparam int unsigned CONV_BASE_CYC  = (CONV_BASE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CONV_CNT_W     = 20;

    typedef logic [WORD_W-1:0] word_t;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_ACCUM
    } conv_state_e;
endpackage

// ### src/result_if.sv
// Interface carrying converted words from the converter core to the readout
`timescale 1ns/1ns
interface result_if;
    import adc_readout_pkg::*;
    logic                valid;
    logic                ready;
    logic [CHAN_IDX_W-1:0] chan;
    word_t               word;
    logic                done;

    modport src (output valid, output chan, output word, output done, input ready);
    modport dst (input valid, input chan, input word, input done, output ready);
endinterface

// ### src/result_buffer.sv
// Two-entry skid buffer between the converter core and the result registers
`timescale 1ns/1ns
module result_buffer
    import adc_readout_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    result_if.dst     up,
    result_if.src     dn
);
    localparam int unsigned ENT_W = CHAN_IDX_W + WORD_W + 1;

    logic [ENT_W-1:0] mem_q [2];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    wire              push = up.valid && up.ready;
    wire              pop  = dn.valid && dn.ready;
    wire [ENT_W-1:0]  head = mem_q[rd_q];

    assign up.ready = (cnt_q != 2'h2);
    assign dn.valid = (cnt_q != 2'h0);
    assign dn.chan  = head[ENT_W-1 -: CHAN_IDX_W];
    assign dn.word  = head[WORD_W:1];
    assign dn.done  = head[0];

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= {up.chan, up.word, up.done};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wr_q <= ~wr_q;
            if (pop)  rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // result_buffer

// ### src/conv_core.sv
// Conversion sequencer with averaging filter feeding the result stream
`timescale 1ns/1ns
module conv_core
    import adc_readout_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                start_i,
    input  wire logic [OSR_W-1:0]    osr_i,
    input  wire logic [CHAN_N*RESULT_W-1:0] sample_i,
    output logic                     busy_o,
    result_if.src                    out
);
    // ------------------------------------------------------------------
    // Sequencer: 2^osr sample periods, then one word per channel
    // ------------------------------------------------------------------
    conv_state_e            state_q;
    logic [CONV_CNT_W-1:0]  tmr_q;
    logic [7:0]             pass_q;
    logic [CHAN_IDX_W-1:0]  ch_q;
    logic [RESULT_W+7-1:0]  acc_q [CHAN_N];

    wire [7:0] passes   = 8'h1 << osr_i;
    wire       tmr_done = (tmr_q == CONV_CNT_W'(CONV_BASE_CYC - 1));
    wire       last_ch  = (ch_q == CHAN_IDX_W'(CHAN_N - 1));
    wire [RESULT_W+7-1:0] avg = acc_q[ch_q] >> osr_i;

    assign busy_o    = (state_q != CONV_IDLE);
    assign out.valid = (state_q == CONV_ACCUM);
    assign out.chan  = ch_q;
    assign out.word  = {avg[RESULT_W-1:0], PAD_ZERO};
    assign out.done  = last_ch;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= CONV_IDLE;
            tmr_q   <= '0;
            pass_q  <= 8'h0;
            ch_q    <= '0;
        end else begin
            case (state_q)
                CONV_IDLE: begin
                    tmr_q  <= '0;
                    pass_q <= 8'h0;
                    ch_q   <= '0;
                    if (start_i) state_q <= CONV_RUN;
                end
                CONV_RUN: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_done) begin
                        tmr_q  <= '0;
                        pass_q <= pass_q + 8'h1;
                        if (pass_q + 8'h1 == passes) state_q <= CONV_ACCUM;
                    end
                end
                CONV_ACCUM: begin
                    if (out.ready) begin
                        ch_q <= ch_q + 1'b1;
                        if (last_ch) state_q <= CONV_IDLE;
                    end
                end
                default: state_q <= CONV_IDLE;
            endcase
        end
    end

    // Averaging filter: one accumulator per channel
    for (genvar c = 0; c < CHAN_N; c++) begin : g_acc
        always_ff @(posedge ref_clk_i) begin
            if (rst_i || (state_q == CONV_IDLE)) begin
                acc_q[c] <= '0;
            end else if (state_q == CONV_RUN && tmr_done) begin
                acc_q[c] <= acc_q[c] + {7'h0, sample_i[c*RESULT_W +: RESULT_W]};
            end
        end
    end
endmodule // conv_core

// ### src/adc_serial_readout_osr.sv
// Serial readout of eight channel results with oversampling control
`timescale 1ns/1ns
module adc_serial_readout_osr
    import adc_readout_pkg::*;
(
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         cs_n_i,
    input  wire logic                         sclk_i,
    input  wire logic                         interface_select_pin_i,
    input  wire logic                         byte_select_pin_i,
    input  wire logic                         convert_start_group1_i,
    input  wire logic                         convert_start_group2_i,
    input  wire logic [adc_readout_pkg::OSR_W-1:0] oversampling_ratio_pins_i,
    input  wire logic [adc_readout_pkg::CHAN_N*adc_readout_pkg::RESULT_W-1:0] sample_i,
    output logic                              busy_o,
    output logic                              serial_out_primary_o,
    output logic                              serial_out_primary_oe_o,
    output logic                              serial_out_secondary_o,
    output logic                              serial_out_secondary_oe_o,
    output logic                              first_channel_flag_o,
    output logic                              first_channel_flag_oe_o
);
    import adc_readout_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sclk_s_q;
    logic [1:0] sel_s_q;
    logic [1:0] byte_s_q;
    logic [1:0] cva_s_q;
    logic [1:0] cvb_s_q;
    logic [OSR_W-1:0] osr_s1_q;
    logic [OSR_W-1:0] osr_s2_q;
    logic       cs_n_q;
    logic       sclk_q;
    logic       cva_q;
    logic       cvb_q;
    logic       arm_a_q;
    logic       arm_b_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cs_s_q   <= 2'h3;
            sclk_s_q <= 2'h0;
            sel_s_q  <= 2'h0;
            byte_s_q <= 2'h0;
            cva_s_q  <= 2'h0;
            cvb_s_q  <= 2'h0;
            osr_s1_q <= '0;
            osr_s2_q <= '0;
        end else begin
            cs_s_q   <= {cs_s_q[0], cs_n_i};
            sclk_s_q <= {sclk_s_q[0], sclk_i};
            sel_s_q  <= {sel_s_q[0], interface_select_pin_i};
            byte_s_q <= {byte_s_q[0], byte_select_pin_i};
            cva_s_q  <= {cva_s_q[0], convert_start_group1_i};
            cvb_s_q  <= {cvb_s_q[0], convert_start_group2_i};
            osr_s1_q <= oversampling_ratio_pins_i;
            osr_s2_q <= osr_s1_q;
        end
    end

    // Delayed copies of the synchronised levels, used for edge detection
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cs_n_q <= 1'b1;
            // Link clock idles low, so reset to that level to avoid a false edge
            sclk_q <= 1'b0;
            cva_q  <= 1'b0;
            cvb_q  <= 1'b0;
        end else begin
            cs_n_q <= cs_s_q[1];
            sclk_q <= sclk_s_q[1];
            cva_q  <= cva_s_q[1];
            cvb_q  <= cvb_s_q[1];
        end
    end

    wire cs_fall   = cs_n_q && !cs_s_q[1];
    wire cs_low    = !cs_s_q[1];
    wire sclk_fall = sclk_q && !sclk_s_q[1];
    wire cva_rise  = !cva_q && cva_s_q[1];
    wire cvb_rise  = !cvb_q && cvb_s_q[1];
    // Only the serial strap setting drives the lines; other modes stay released
    wire ser_mode  = sel_s_q[1] && !byte_s_q[1];

    // ------------------------------------------------------------------
    // Conversion start: both groups must be sampled before converting
    // ------------------------------------------------------------------
    logic             busy_w;
    logic             busy_q;
    logic [OSR_W-1:0] osr_q;
    wire arm_a_n = arm_a_q || cva_rise;
    wire arm_b_n = arm_b_q || cvb_rise;
    wire start   = arm_a_n && arm_b_n && !busy_w;
    wire busy_fall = busy_q && !busy_w;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || start) begin
            arm_a_q <= 1'b0;
            arm_b_q <= 1'b0;
        end else begin
            arm_a_q <= arm_a_n;
            arm_b_q <= arm_b_n;
        end
    end

    // Ratio for the next conversion is captured at the end of this one
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osr_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_w;
            if (busy_fall) osr_q <= osr_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Converter core and buffered result stream
    // ------------------------------------------------------------------
    result_if core_s ();
    result_if buf_s ();

    conv_core u_core (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .start_i   (start),
        .osr_i     (osr_q),
        .sample_i  (sample_i),
        .busy_o    (busy_w),
        .out       (core_s.src)
    );

    result_buffer u_buf (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .up        (core_s.dst),
        .dn        (buf_s.src)
    );

    // ------------------------------------------------------------------
    // Result registers: staged, then published together
    // ------------------------------------------------------------------
    word_t stage_q [CHAN_N];
    word_t res_q   [CHAN_N];
    logic  publish_q;

    // Staging always has room; the set only goes live after its last word lands
    assign buf_s.ready = 1'b1;

    always_ff @(posedge ref_clk_i) begin
        if (buf_s.valid && buf_s.ready) begin
            stage_q[buf_s.chan] <= buf_s.word;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            publish_q <= 1'b0;
        end else begin
            publish_q <= buf_s.valid && buf_s.ready && buf_s.done;
        end
    end

    // Results in flight stay staged while busy is high, so reads see the old set
    for (genvar c = 0; c < CHAN_N; c++) begin : g_res
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                res_q[c] <= '0;
            end else if (publish_q) begin
                res_q[c] <= stage_q[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------------
    logic [BIT_CNT_W-1:0]  bit_q;
    logic [CHAN_IDX_W-1:0] slot_q;
    logic                  oe_q;
    logic                  out_a_q;
    logic                  out_b_q;
    logic                  frst_q;

    wire last_bit = (bit_q == LAST_BIT);
    wire [BIT_CNT_W-1:0]  bit_n  = last_bit ? '0 : bit_q + 1'b1;
    wire [CHAN_IDX_W-1:0] slot_n = last_bit ? slot_q + 1'b1 : slot_q;
    wire [CHAN_IDX_W-1:0] slot_b = slot_n ^ CHAN_IDX_W'(GROUP_N);
    wire [3:0] bit_pos = 4'(WORD_W - 1) - bit_n;
    wire       bit_a   = res_q[slot_n][bit_pos];
    wire       bit_b   = res_q[slot_b][bit_pos];
    // Slot 0 carries channel one on primary and channel five on secondary
    wire       frst_n  = (slot_n == '0);
    wire [3:0] msb_pos = 4'(WORD_W - 1);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bit_q   <= '0;
            slot_q  <= '0;
            oe_q    <= 1'b0;
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            frst_q  <= 1'b0;
        end else if (!cs_low || !ser_mode) begin
            oe_q <= 1'b0;
        end else if (cs_fall) begin
            // Slot persists across frames while the bit count restarts, so per-channel framing resumes
            oe_q    <= 1'b1;
            bit_q   <= '0;
            out_a_q <= res_q[slot_q][msb_pos];
            out_b_q <= res_q[slot_q ^ CHAN_IDX_W'(GROUP_N)][msb_pos];
            frst_q  <= (slot_q == '0);
        end else if (sclk_fall) begin
            bit_q   <= bit_n;
            slot_q  <= slot_n;
            out_a_q <= bit_a;
            out_b_q <= bit_b;
            frst_q  <= frst_n;
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_o                    <= 1'b0;
            serial_out_primary_o      <= 1'b0;
            serial_out_primary_oe_o   <= 1'b0;
            serial_out_secondary_o    <= 1'b0;
            serial_out_secondary_oe_o <= 1'b0;
            first_channel_flag_o      <= 1'b0;
            first_channel_flag_oe_o   <= 1'b0;
        end else begin
            busy_o                    <= busy_w;
            serial_out_primary_o      <= out_a_q;
            serial_out_primary_oe_o   <= oe_q;
            serial_out_secondary_o    <= out_b_q;
            serial_out_secondary_oe_o <= oe_q;
            first_channel_flag_o      <= frst_q;
            first_channel_flag_oe_o   <= oe_q;
        end
    end
endmodule // adc_serial_readout_osr

// ### tb/adc_readout_props.sv
// Concurrent checks on the serial readout block ports
`timescale 1ns/1ns
module adc_readout_props (
    input  wire logic                                ref_clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                cs_n_i,
    input  wire logic                                sclk_i,
    input  wire logic                                interface_select_pin_i,
    input  wire logic                                byte_select_pin_i,
    input  wire logic [adc_readout_pkg::OSR_W-1:0]   oversampling_ratio_pins_i,
    input  wire logic                                busy_o,
    input  wire logic                                serial_out_primary_o,
    input  wire logic                                serial_out_primary_oe_o,
    input  wire logic                                serial_out_secondary_o,
    input  wire logic                                serial_out_secondary_oe_o,
    input  wire logic                                first_channel_flag_o,
    input  wire logic                                first_channel_flag_oe_o
);
    import adc_readout_pkg::*;

    // ------------------------------------------------------------------
    // Busy length bookkeeping
    // ------------------------------------------------------------------
    logic [19:0]      busy_len_q;
    logic [OSR_W-1:0] ratio_q;
    logic             busy_was_q;
    wire  [19:0]      conv_len_w = 20'(CONV_BASE_CYC) << ratio_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_len_q <= '0;
            ratio_q    <= '0;
            busy_was_q <= 1'b0;
        end else begin
            busy_len_q <= busy_o ? busy_len_q + 20'h1 : 20'h0;
            busy_was_q <= busy_o;
            if (busy_was_q && !busy_o) begin
                ratio_q <= oversampling_ratio_pins_i;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Pins pass a synchroniser, so every reaction is given a few cycles
    sequence cs_idle_s;
        cs_n_i [*8];
    endsequence
    sequence serial_sel_s;
        interface_select_pin_i && !byte_select_pin_i;
    endsequence
    sequence link_quiet_s;
        (sclk_i == $past(sclk_i) && !cs_n_i && !$past(cs_n_i)) [*8];
    endsequence

    a_idle_released: assert property (
        cs_idle_s |-> !serial_out_primary_oe_o && !serial_out_secondary_oe_o
                      && !first_channel_flag_oe_o)
        else $error("outputs driven while chip select high");
    a_release_on_cs: assert property (
        $rose(cs_n_i) |-> ##[1:8] !serial_out_primary_oe_o && !first_channel_flag_oe_o)
        else $error("outputs not released after chip select rise");
    a_drive_on_cs: assert property (
        $fell(cs_n_i) ##0 serial_sel_s |-> ##[1:8] serial_out_primary_oe_o
                      && serial_out_secondary_oe_o && first_channel_flag_oe_o)
        else $error("outputs not enabled after chip select fall");
    a_oe_together: assert property (
        serial_out_primary_oe_o |-> serial_out_secondary_oe_o && first_channel_flag_oe_o)
        else $error("serial enables not together");
    a_strap_refused: assert property (
        (!interface_select_pin_i || byte_select_pin_i) [*8] |-> !serial_out_primary_oe_o
                      && !serial_out_secondary_oe_o)
        else $error("serial output in non-serial mode");
    a_bits_hold: assert property (
        link_quiet_s |-> $stable(serial_out_primary_o) && $stable(serial_out_secondary_o)
                      && $stable(first_channel_flag_o))
        else $error("serial output moved without clock edge");
    a_busy_min_len: assert property (
        $fell(busy_o) |-> busy_len_q >= conv_len_w)
        else $error("busy shorter than ratio demands");
    a_busy_max_len: assert property (
        $fell(busy_o) |-> busy_len_q <= conv_len_w + 20'h28)
        else $error("busy longer than ratio demands");
endmodule // adc_readout_props

bind adc_serial_readout_osr adc_readout_props u_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .interface_select_pin_i(interface_select_pin_i), .byte_select_pin_i(byte_select_pin_i),
    .oversampling_ratio_pins_i(oversampling_ratio_pins_i), .busy_o(busy_o),
    .serial_out_primary_o(serial_out_primary_o),
    .serial_out_primary_oe_o(serial_out_primary_oe_o),
    .serial_out_secondary_o(serial_out_secondary_o),
    .serial_out_secondary_oe_o(serial_out_secondary_oe_o),
    .first_channel_flag_o(first_channel_flag_o),
    .first_channel_flag_oe_o(first_channel_flag_oe_o)
);

// ### tb/host_reader.sv
// Serial host model: frames reads, clocks bits and captures both lines
`timescale 1ns/1ns
module host_reader (
    input  wire logic pri_i,
    input  wire logic pri_oe_i,
    input  wire logic sec_i,
    input  wire logic sec_oe_i,
    input  wire logic flag_i,
    output logic      cs_n_o,
    output logic      sclk_o
);
    logic [13:0] pri_q [$];
    logic [13:0] sec_q [$];
    logic [1:0]  flag_q [$];

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end

    // Link clock of 125 ns, idle low between frames
    task automatic read_chans(input int n, input bit framed);
        logic [13:0] a;
        logic [13:0] b;
        logic [1:0]  f;
        for (int c = 0; c < n; c++) begin
            if (framed || c == 0) begin
                cs_n_o = 1'b0;
                #125;
            end
            for (int i = 0; i < 14; i++) begin
                sclk_o = 1'b1;
                #62;
                a[13-i] = (pri_oe_i === 1'b1) ? pri_i : 1'bx;
                b[13-i] = (sec_oe_i === 1'b1) ? sec_i : 1'bx;
                if (i == 0) f[1] = flag_i;
                if (i == 13) f[0] = flag_i;
                sclk_o = 1'b0;
                #63;
            end
            pri_q.push_back(a);
            sec_q.push_back(b);
            flag_q.push_back(f);
            if (framed || c == n - 1) begin
                #62;
                cs_n_o = 1'b1;
                #125;
            end
        end
    endtask

    task automatic idle_clocks(input int n);
        repeat (n) begin
            sclk_o = 1'b1;
            #62;
            sclk_o = 1'b0;
            #63;
        end
    endtask
endmodule // host_reader

// ### tb/tb.sv
// Self-checking bench for the serial readout block
`timescale 1ns/1ns
module tb;
    import adc_readout_pkg::*;
    logic                       ref_clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic                       interface_select_pin = 1'b1;
    logic                       byte_select_pin = 1'b0;
    logic                       start1 = 1'b0;
    logic                       start2 = 1'b0;
    logic [OSR_W-1:0]           os_pins = '0;
    logic [CHAN_N*RESULT_W-1:0] sample = '0;
    logic                       busy, pri, pri_oe, sec, sec_oe, flag, flag_oe, cs_n, sclk;
    logic [RESULT_W-1:0]        exp_res [CHAN_N] = '{default: '0};
    int                         err_total = 0;
    int                         n_compared = 0;
    int                         pos = 0;
    int                         exp_ratio = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    adc_serial_readout_osr uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .interface_select_pin_i(interface_select_pin), .byte_select_pin_i(byte_select_pin),
        .convert_start_group1_i(start1), .convert_start_group2_i(start2),
        .oversampling_ratio_pins_i(os_pins), .sample_i(sample), .busy_o(busy),
        .serial_out_primary_o(pri), .serial_out_primary_oe_o(pri_oe),
        .serial_out_secondary_o(sec), .serial_out_secondary_oe_o(sec_oe),
        .first_channel_flag_o(flag), .first_channel_flag_oe_o(flag_oe)
    );
    host_reader host (
        .pri_i(pri), .pri_oe_i(pri_oe), .sec_i(sec), .sec_oe_i(sec_oe), .flag_i(flag),
        .cs_n_o(cs_n), .sclk_o(sclk)
    );

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic timeout();
        err_total++;
        $display("MISMATCH t=%0t wait limit used up", $time);
        final_report();
    endtask

    // ------------------------------------------------------------------
    // Reads and conversions against the reference model
    // ------------------------------------------------------------------
    task automatic read_chk(input int n, input bit framed);
        logic [RESULT_W-1:0] a;
        logic [RESULT_W-1:0] b;
        logic [1:0]          f;
        host.read_chans(n, framed);
        for (int c = 0; c < n; c++) begin
            a = host.pri_q.pop_front();
            b = host.sec_q.pop_front();
            f = host.flag_q.pop_front();
            check(a, exp_res[pos]);
            check(b, exp_res[(pos + 4) % 8]);
            check(14'(f), (pos == 0) ? 14'h3 : 14'h0);
            pos = (pos + 1) % 8;
        end
    endtask

    // Starts both groups together, optionally reads during busy, times busy
    task automatic convert(input logic [OSR_W-1:0] next_os, input int n);
        logic [CHAN_N*RESULT_W-1:0] s;
        int                         cnt;
        int                         lim;
        for (int c = 0; c < CHAN_N; c++) s[c*RESULT_W +: RESULT_W] = RESULT_W'($urandom);
        @(posedge ref_clk_i);
        sample <= s;
        os_pins <= next_os;
        start1 <= 1'b1;
        start2 <= 1'b1;
        @(posedge ref_clk_i);
        start1 <= 1'b0;
        start2 <= 1'b0;
        cnt = 0;
        while (busy !== 1'b1 && cnt < 50) begin
            @(posedge ref_clk_i);
            cnt++;
        end
        if (cnt == 50) timeout();
        lim = CONV_BASE_CYC << exp_ratio;
        cnt = 0;
        fork
            if (n > 0) begin
                read_chk(n, 1'b1);
                check(14'(busy), 14'h1);
            end
            while (busy === 1'b1 && cnt < 200000) begin
                @(posedge ref_clk_i);
                cnt++;
            end
        join
        if (cnt == 200000) timeout();
        check(14'(cnt + 2 >= lim && cnt <= lim + 40), 14'h1);
        for (int c = 0; c < CHAN_N; c++) exp_res[c] = s[c*RESULT_W +: RESULT_W];
        exp_ratio = next_os;
    endtask

    initial begin
        void'($urandom(72908));
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        read_chk(8, 1'b0);
        convert(3'h2, 0);
        read_chk(8, 1'b0);
        convert(3'h3, 4);
        host.idle_clocks(14);
        read_chk(4, 1'b1);
        convert(3'h0, 4);
        read_chk(8, 1'b0);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk_i);
            interface_select_pin <= 1'(k);
            byte_select_pin <= 1'(k);
            fork
                host.read_chans(1, 1'b1);
                begin
                    #300;
                    check(14'({pri_oe, sec_oe, flag_oe}), 14'h0);
                end
            join
            host.pri_q.delete();
            host.sec_q.delete();
            host.flag_q.delete();
        end
        final_report();
    end
endmodule // tb
